// ==== lpc_pkg.sv ====
// Shared constants and types for the firmware read target.
package lpc_pkg;

  // ==========================================================================
  // Cycle codes
  localparam logic [3:0] START_LPC_MEMORY  = 4'h0;
  localparam logic [3:0] START_FW_READ     = 4'hd;
  localparam logic [3:0] START_FW_WRITE    = 4'he;
  localparam logic [3:0] SIZE_SINGLE_BYTE  = 4'h0;
  localparam logic [3:0] READY_SYNC_CODE   = 4'h0;
  localparam logic [3:0] TURNAROUND_CODE   = 4'hf;

  // ==========================================================================
  // Identification
  localparam logic [18:0] ID_MAKER_OFFSET  = 19'h0_0000;
  localparam logic [18:0] ID_PART_OFFSET   = 19'h0_0001;
  localparam logic [27:0] ID_LPC_BASE      = 28'hfbc_0000;
  localparam int          ID_STRAP_SHIFT   = 22;
  localparam int          ADDRESS_NIBBLES  = 7;
  localparam logic [2:0]  LAST_NIBBLE      = 3'h6;

  // ==========================================================================
  // Parallel address split
  localparam int ROW_BITS    = 11;
  localparam int COLUMN_BITS = 8;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    CYCLE_NONE,
    CYCLE_LPC_MEMORY,
    CYCLE_FW_READ,
    CYCLE_FW_WRITE
  } cycle_kind_t;

  typedef struct packed {
    logic [3:0] out;
    logic       enable;
  } lad_drive_t;

  typedef struct packed {
    logic        request;
    logic [18:0] address;
  } array_read_t;

endpackage

// ==== parallel_address_latch.sv ====
// Row and column address latch for parallel programming mode.
`timescale 1ns/1ps
module parallel_address_latch
  import lpc_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic [ROW_BITS-1:0]    address_pins,
  input  wire logic                   row_column_select,
  output logic      [18:0]            internal_address
);

  logic [ROW_BITS-1:0]    pins_meta;
  logic [ROW_BITS-1:0]    pins_sync;
  logic                   select_meta;
  logic                   select_sync;
  logic [ROW_BITS-1:0]    row;
  logic [COLUMN_BITS-1:0] column;
  logic [ROW_BITS-1:0]    next_row;
  logic [COLUMN_BITS-1:0] next_column;

  // ==========================================================================
  // Latching
  // multiplexed row column
  always_comb begin
    next_row    = row;
    next_column = column;
    if (select_sync) begin
      next_row = pins_sync;
    end else begin
      next_column = pins_sync[COLUMN_BITS-1:0];
    end
  end

  // Pins and select share one two-flop path, so a row never pairs with a stale select.
  always_ff @(posedge clock) begin
    if (rst) begin
      pins_meta   <= '0;
      pins_sync   <= '0;
      select_meta <= 1'b0;
      select_sync <= 1'b0;
      row         <= '0;
      column      <= '0;
    end else begin
      pins_meta   <= address_pins;
      pins_sync   <= pins_meta;
      select_meta <= row_column_select;
      select_sync <= select_meta;
      row         <= next_row;
      column      <= next_column;
    end
  end

  assign internal_address = {column, row};

endmodule

// ==== lpc_firmware_read_target.sv ====
// Firmware memory read target on the low pin count link, with identification.
`timescale 1ns/1ps
module lpc_firmware_read_target
  import lpc_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5a,
  parameter logic [7:0] PART_CODE  = 8'ha5
)(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                link_clock,
  input  wire logic                frame_n,
  input  wire logic [3:0]          lad_in,
  output logic      [3:0]          lad_out,
  output logic                     lad_oe,
  input  wire logic                reset_n,
  input  wire logic                init_n,
  input  wire logic                mode_pin,
  input  wire logic [3:0]          strap_select_pins,
  input  wire logic [ROW_BITS-1:0] parallel_address,
  input  wire logic                row_column_select,
  input  wire logic                program_busy,
  input  wire logic [7:0]          array_data,
  output logic      [18:0]         array_address,
  output logic                     array_read,
  output logic                     identification_mode_seen,
  output logic [7:0]               parallel_data_lines,
  output logic                     standby,
  output logic                     parallel_programming,
  output logic [1:0]               cycle_kind
);

  typedef enum {
    IDLE, START, ADDRESS, SIZE, TURN_FIRST, TURN_SECOND, SYNC, DATA_LOW, DATA_HIGH, TURN_BACK, IGNORE
  } state_t;

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] link_sync, frame_sync, reset_sync, init_sync, mode_sync;
  logic [3:0] lad_meta, lad_sync, strap_meta, strap_sync;
  logic       link_prev;

  always_ff @(posedge clock) begin
    if (rst) begin
      link_sync  <= 2'h3;
      frame_sync <= 2'h3;
      reset_sync <= '0;
      init_sync  <= '0;
      mode_sync  <= '0;
      lad_meta   <= 4'hf;
      lad_sync   <= 4'hf;
      strap_meta <= '0;
      strap_sync <= '0;
      link_prev  <= 1'b1;
    end else begin
      link_sync  <= {link_sync[0], link_clock};
      frame_sync <= {frame_sync[0], frame_n};
      reset_sync <= {reset_sync[0], reset_n};
      init_sync  <= {init_sync[0], init_n};
      mode_sync  <= {mode_sync[0], mode_pin};
      lad_meta   <= lad_in;
      lad_sync   <= lad_meta;
      strap_meta <= strap_select_pins;
      strap_sync <= strap_meta;
      link_prev  <= link_sync[1];
    end
  end

  logic link_rise;
  assign link_rise = link_sync[1] & ~link_prev;

  logic pin_reset;
  assign pin_reset = ~reset_sync[1] | ~init_sync[1];

  logic lpc_mode;
  assign lpc_mode = ~mode_sync[1];

  // ==========================================================================
  // Parallel address path
  logic [18:0] pp_address;

  parallel_address_latch u_latch (
    .clock             (clock),
    .rst               (rst),
    .address_pins      (parallel_address),
    .row_column_select (row_column_select),
    .internal_address  (pp_address)
  );

  // ==========================================================================
  // Link state machine
  state_t      state, next_state;
  logic [3:0]  start_code, next_start_code;
  logic [2:0]  nibble, next_nibble;
  logic [27:0] address, next_address;
  logic [7:0]  read_byte, next_read_byte;
  lad_drive_t  drive, next_drive;
  logic [1:0]  kind, next_kind;

  logic [27:0] id_base;
  assign id_base = ID_LPC_BASE - (28'(strap_sync) << ID_STRAP_SHIFT);

  logic id_hit;
  assign id_hit = (address[27:1] == id_base[27:1]);

  always_comb begin
    next_state      = state;
    next_start_code = start_code;
    next_nibble     = nibble;
    next_address    = address;
    next_read_byte  = read_byte;
    next_drive      = drive;
    next_kind       = kind;
    if (link_rise) begin
      // start taken at last low clock
      if (!frame_sync[1]) begin
        next_state      = START;
        next_start_code = lad_sync;
        next_drive      = '0;
      end else begin
        unique case (state)
          IDLE: begin
            next_drive = '0;
          end
          START: begin
            unique case (start_code)
              START_LPC_MEMORY: next_kind = CYCLE_LPC_MEMORY;
              START_FW_READ:    next_kind = CYCLE_FW_READ;
              START_FW_WRITE:   next_kind = CYCLE_FW_WRITE;
              default:          next_kind = CYCLE_NONE;
            endcase
            if (start_code == START_FW_READ && lad_sync == strap_sync) begin
              next_state  = ADDRESS;
              next_nibble = '0;
            end else begin
              next_state = IGNORE;
            end
          end
          ADDRESS: begin
            next_address = {address[23:0], lad_sync};
            next_nibble  = nibble + 3'h1;
            if (nibble == LAST_NIBBLE) begin
              next_state = SIZE;
            end
          end
          SIZE: begin
            next_state = (lad_sync == SIZE_SINGLE_BYTE) ? TURN_FIRST : IGNORE;
          end
          TURN_FIRST: begin
            next_state      = TURN_SECOND;
            next_drive.out    = TURNAROUND_CODE;
            next_drive.enable = 1'b1;
            if (id_hit && address[0] == ID_PART_OFFSET[0]) begin
              next_read_byte = PART_CODE;
            end else if (id_hit) begin
              next_read_byte = MAKER_CODE;
            end else begin
              next_read_byte = array_data;
            end
          end
          TURN_SECOND: begin
            next_state     = SYNC;
            next_drive.out = READY_SYNC_CODE;
          end
          SYNC: begin
            next_state     = DATA_LOW;
            next_drive.out = read_byte[3:0];
          end
          DATA_LOW: begin
            next_state     = DATA_HIGH;
            next_drive.out = read_byte[7:4];
          end
          DATA_HIGH: begin
            next_state     = TURN_BACK;
            next_drive.out = TURNAROUND_CODE;
          end
          TURN_BACK: begin
            next_state = IDLE;
            next_drive = '0;
          end
          IGNORE: begin
            next_drive = '0;
          end
        endcase
      end
    end
    if (pin_reset || !lpc_mode) begin
      next_state = IDLE;
      next_drive = '0;
    end
  end

  // Array data is sampled two link clocks after the address settles.
  always_ff @(posedge clock) begin
    if (rst) begin
      state      <= IDLE;
      start_code <= 4'hf;
      nibble     <= '0;
      address    <= '0;
      read_byte  <= '0;
      drive      <= '0;
      kind       <= CYCLE_NONE;
    end else begin
      state      <= next_state;
      start_code <= next_start_code;
      nibble     <= next_nibble;
      address    <= next_address;
      read_byte  <= next_read_byte;
      drive      <= next_drive;
      kind       <= next_kind;
    end
  end

  // ==========================================================================
  // Outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      lad_out                  <= 4'hf;
      lad_oe                   <= 1'b0;
      array_address            <= '0;
      array_read               <= 1'b0;
      identification_mode_seen <= 1'b0;
      parallel_data_lines      <= '0;
      standby                  <= 1'b1;
      parallel_programming     <= 1'b0;
      cycle_kind               <= CYCLE_NONE;
    end else begin
      lad_out                  <= next_drive.out;
      lad_oe                   <= next_drive.enable & ~pin_reset;
      array_address            <= lpc_mode ? address[18:0] : pp_address;
      array_read               <= (state == TURN_FIRST) | ~lpc_mode;
      identification_mode_seen <= lpc_mode ? id_hit : (pp_address[18:1] == ID_MAKER_OFFSET[18:1]);
      parallel_data_lines      <= (pp_address == ID_PART_OFFSET) ? PART_CODE :
                                  (pp_address == ID_MAKER_OFFSET) ? MAKER_CODE : array_data;
      standby                  <= frame_sync[1] & ~program_busy & (state == IDLE || state == IGNORE);
      parallel_programming     <= ~lpc_mode;
      cycle_kind               <= next_kind;
    end
  end

endmodule

// ==== lpc_read_monitor.sv ====
// Port assertions for the firmware read target.
`timescale 1ns/1ps
module lpc_read_monitor
  import lpc_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       frame_n,
  input wire logic [3:0] lad_out,
  input wire logic       lad_oe,
  input wire logic       reset_n,
  input wire logic       init_n,
  input wire logic       mode_pin,
  input wire logic       program_busy,
  input wire logic       standby,
  input wire logic       parallel_programming
);
  // ==========================================================================
  // Helpers
  // Drive window bound assumes a 48 ns link period, so about seven link periods.
  localparam int OE_MAX = 70;
  logic [7:0] oe_cnt;
  logic [7:0] next_oe_cnt;
  logic       moved;
  logic       next_moved;
  always_comb begin
    next_oe_cnt = (rst || !lad_oe) ? 8'h00 : oe_cnt + 8'h01;
    next_moved  = !rst && lad_oe && (moved || lad_out != TURNAROUND_CODE);
  end
  always_ff @(posedge clock) begin
    oe_cnt <= next_oe_cnt;
    moved  <= next_moved;
  end
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence pins_reset; !(reset_n && init_n); endsequence
  sequence drive_open; $rose(lad_oe); endsequence
  a_reset_float:
    assert property (pins_reset |-> ##[0:6] !lad_oe) else $error("link driven during pin reset");
  a_abort_float:
    assert property ($fell(frame_n) |-> ##[0:14] !lad_oe) else $error("link driven after frame drop");
  a_first_drive:
    assert property (drive_open |-> lad_out == TURNAROUND_CODE) else $error("first driven nibble not ones");
  a_sync_first:
    assert property (lad_oe && !moved && lad_out != TURNAROUND_CODE |-> lad_out == READY_SYNC_CODE)
      else $error("ready sync missing");
  a_release_ones:
    assert property ($fell(lad_oe) && reset_n && init_n && frame_n |-> $past(lad_out) == TURNAROUND_CODE)
      else $error("release without ones");
  a_drive_bound:
    assert property (oe_cnt <= OE_MAX) else $error("link driven too long");
  a_busy_wakes:
    assert property (program_busy [*5] |-> !standby) else $error("standby while busy");
  a_mode_high:
    assert property (mode_pin [*6] |-> parallel_programming) else $error("parallel mode missed");
  a_mode_low:
    assert property (!mode_pin [*6] |-> !parallel_programming) else $error("link mode missed");
endmodule
bind lpc_firmware_read_target lpc_read_monitor mon (.clock, .rst, .frame_n, .lad_out, .lad_oe, .reset_n,
  .init_n, .mode_pin, .program_busy, .standby, .parallel_programming);

// ==== lpc_host_model.sv ====
// Host side of the link: free-running link clock and firmware read cycles.
`timescale 1ns/1ps
module lpc_host_model (
  output logic            link_clock,
  output logic            frame_n,
  output wire logic [3:0] lad_in,
  input  wire logic [3:0] lad_out,
  input  wire logic       lad_oe
);
  logic [3:0] host_lad = 4'hf;
  logic       host_oe = 1'b1;
  initial link_clock = 1'b0;
  initial frame_n = 1'b1;
  always #24 link_clock = ~link_clock;
  // pull-ups give ones once both sides have let go
  assign lad_in = lad_oe ? lad_out : (host_oe ? host_lad : 4'hf);
  task automatic send(input logic fr, input logic [3:0] v);
    @(negedge link_clock);
    frame_n = fr;
    host_lad = v;
    host_oe = 1'b1;
  endtask
  // frame with start, select, address top nibble first, size
  task automatic fw_cycle(input logic [3:0] pre, st, sel, input logic [27:0] a, input logic [3:0] sz,
      input int nf, output logic [20:0] seen);
    seen = 21'h0;
    if (pre != st) send(1'b0, pre);
    send(1'b0, st);
    send(1'b1, sel);
    for (int i = 0; i < nf; i++) send(1'b1, i < 7 ? a[27 - 4 * i -: 4] : sz);
    if (nf == 8) begin
      // ones for one clock, then float
      send(1'b1, 4'hf);
      @(negedge link_clock);
      host_oe = 1'b0;
      repeat (6) begin
        @(posedge link_clock);
        seen = {lad_oe, seen[15:0], lad_in};
      end
      send(1'b1, 4'hf);
    end
  endtask
  // frame drops while the device drives, and stays low for the next start
  task automatic cut_read(input logic [27:0] a, output logic [20:0] seen);
    seen = 21'h00_0000;
    send(1'b0, 4'hd);
    send(1'b1, 4'h0);
    for (int i = 0; i < 7; i++) send(1'b1, a[27 - 4 * i -: 4]);
    send(1'b1, 4'h0);
    send(1'b1, 4'hf);
    @(negedge link_clock);
    host_oe = 1'b0;
    repeat (2) @(posedge link_clock);
    seen[1] = lad_oe;
    send(1'b0, 4'hf);
    @(negedge link_clock);
    seen[0] = lad_oe;
  endtask
endmodule

// ==== lpc_firmware_read_target_bench.sv ====
// Self-checking bench for the firmware read target.
`timescale 1ns/1ps
module lpc_firmware_read_target_bench;
  import lpc_pkg::*;
  // Arbitrary identification codes.
  localparam logic [7:0] MAKER = 8'h3c;
  localparam logic [7:0] PART = 8'hc3;
  logic clock = 1'b0, rst = 1'b1, reset_n = 1'b1, init_n = 1'b1, mode_pin = 1'b0;
  logic row_column_select = 1'b0, program_busy = 1'b0;
  logic [3:0] strap_select_pins = 4'h0;
  logic [10:0] parallel_address = 11'h000;
  logic [7:0] array_data = 8'h00, parallel_data_lines;
  logic link_clock, frame_n, lad_oe, identification_mode_seen, standby, parallel_programming, array_read;
  logic [3:0] lad_in, lad_out;
  logic [18:0] array_address;
  logic [1:0] cycle_kind;
  logic [20:0] seen;
  int error_cnt = 0;
  int n_compared = 0;
  always #2.5 clock = ~clock;
  lpc_firmware_read_target #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dut (.clock, .rst, .link_clock,
    .frame_n, .lad_in, .lad_out, .lad_oe, .reset_n, .init_n, .mode_pin, .strap_select_pins,
    .parallel_address, .row_column_select, .program_busy, .array_data, .array_address, .array_read,
    .identification_mode_seen, .parallel_data_lines, .standby, .parallel_programming, .cycle_kind);
  lpc_host_model host (.link_clock, .frame_n, .lad_in, .lad_out, .lad_oe);
  function automatic logic [7:0] byte_at(input logic [18:0] a);
    return a[7:0] ^ a[18:11] ^ 8'h96;
  endfunction
  always @(posedge clock) array_data <= byte_at(array_address);
  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [20:0] got, input logic [20:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
  endtask
  // A hit shows sync, low nibble, high nibble, ones, then a floating bus.
  task automatic rd(input logic [3:0] pre, st, sel, input logic [27:0] a, input logic [3:0] sz,
      input logic hit, input logic [7:0] d);
    host.fw_cycle(pre, st, sel, a, sz, 8, seen);
    check(seen, hit ? {1'b0, 4'h0, d[3:0], d[7:4], 8'hff} : 21'h0f_ffff);
    ticks(1);
  endtask
  task automatic pp_addr(input logic [10:0] row, input logic [7:0] col);
    row_column_select <= 1'b1;
    parallel_address <= row;
    ticks(4);
    row_column_select <= 1'b0;
    parallel_address <= {3'h0, col};
    ticks(10);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reads();
    rd(4'hd, 4'hd, 4'h0, 28'hff1_2345, 4'h0, 1'b1, byte_at(19'h1_2345));
    check({20'h0, identification_mode_seen}, 21'h0);
    rd(4'hd, 4'hd, 4'h0, ID_LPC_BASE, 4'h0, 1'b1, MAKER);
    check({20'h0, identification_mode_seen}, 21'h1);
    rd(4'hd, 4'hd, 4'h0, ID_LPC_BASE + 28'h1, 4'h0, 1'b1, PART);
    rd(4'h0, 4'hd, 4'h0, 28'hff0_0010, 4'h0, 1'b1, byte_at(19'h0_0010));
    rd(4'hd, 4'hd, 4'h0, 28'hff0_0010, 4'h1, 1'b0, 8'h00);
    rd(4'h5, 4'h5, 4'h0, 28'hff0_0010, 4'h0, 1'b0, 8'h00);
    strap_select_pins <= 4'h2;
    rd(4'hd, 4'hd, 4'h2, ID_LPC_BASE - 28'h080_0000, 4'h0, 1'b1, MAKER);
    rd(4'hd, 4'hd, 4'h0, 28'hff0_0010, 4'h0, 1'b0, 8'h00);
    strap_select_pins <= 4'h0;
  endtask
  task automatic t_kinds();
    logic [3:0] st [4] = '{4'h0, 4'hd, 4'he, 4'h5};
    logic [1:0] kd [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    for (int i = 0; i < 4; i++) begin
      host.fw_cycle(st[i], st[i], 4'h0, 28'h000_0000, 4'h0, 0, seen);
      ticks(12);
      check({19'h0, cycle_kind}, {19'h0, kd[i]});
    end
    host.cut_read(28'hff0_0040, seen);
    check(seen, 21'h00_0002);
    rd(4'hd, 4'hd, 4'h0, 28'hff0_0020, 4'h0, 1'b1, byte_at(19'h0_0020));
  endtask
  task automatic t_pin_reset();
    int n;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      fork
        host.fw_cycle(4'hd, 4'hd, 4'h0, 28'hff0_0030, 4'h0, 8, seen);
        begin
          while (lad_oe !== 1'b1 && n < 2000) begin
            ticks(1);
            n++;
          end
          if (lad_oe !== 1'b1) begin
            check({20'h0, lad_oe}, 21'h1);
            end_sim();
          end
          if (p == 0) reset_n <= 1'b0;
          else init_n <= 1'b0;
          ticks(8);
          check({20'h0, lad_oe}, 21'h0);
        end
      join
      ticks(1);
      reset_n <= 1'b1;
      init_n <= 1'b1;
      ticks(10);
    end
  endtask
  task automatic t_standby();
    ticks(20);
    check({20'h0, standby}, 21'h1);
    program_busy <= 1'b1;
    ticks(8);
    check({20'h0, standby}, 21'h0);
    program_busy <= 1'b0;
  endtask
  task automatic t_parallel();
    mode_pin <= 1'b1;
    pp_addr(11'h345, 8'ha5);
    check({2'h0, array_address}, {2'h0, 8'ha5, 11'h345});
    check({13'h0, parallel_data_lines}, {13'h0, byte_at({8'ha5, 11'h345})});
    check({20'h0, identification_mode_seen}, 21'h0);
    check({20'h0, array_read}, 21'h1);
    pp_addr(11'h000, 8'h00);
    check({13'h0, parallel_data_lines}, {13'h0, MAKER});
    check({20'h0, identification_mode_seen}, 21'h1);
    pp_addr(11'h001, 8'h00);
    check({13'h0, parallel_data_lines}, {13'h0, PART});
    check({20'h0, parallel_programming}, 21'h1);
    mode_pin <= 1'b0;
    ticks(8);
    check({20'h0, parallel_programming}, 21'h0);
  endtask
  initial begin
    ticks(4);
    rst <= 1'b0;
    ticks(4);
    t_reads();
    t_kinds();
    t_pin_reset();
    t_standby();
    t_parallel();
    end_sim();
  end
endmodule
